// file: rtl/spis_buf2.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ns
module spis_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_out = cnt_reg != (PTR_W+1)'(DEPTH);
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PTR_W'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= PTR_W'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : spis_buf2

// file: rtl/spis_pkg.sv
// shared constants, types and crc arithmetic of the serial port
package spis_pkg;
  localparam int FRAME_W = 8;
  // --------------------------------------------------------------------
  // counts and reset values
  // --------------------------------------------------------------------
  // five clocks a half period: a slave's answer to a fall passes the input
  // synchroniser before the next master rise samples it
  localparam logic [3:0] SCK_HALF_CYC = 4'h4;
  localparam logic [3:0] FB_WIN_SPI = 4'h7;
  localparam logic [3:0] FB_WIN_I2S = 4'h5;
  localparam logic [3:0] FB_CNT_RST = 4'h0;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] SYNC_RST = 4'h4;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_SECOND = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] CRC_RST = 8'h00;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam int BUF_DEPTH = 2;
  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FBWAIT = 3'b100
  } spis_state_e;
  typedef struct packed {
    logic port_enable_bit;
    logic master_select_bit;
    logic receive_only_bit;
    logic half_duplex_bit;
    logic half_duplex_output_enable;
    logic crc_en;
    logic i2s_mode;
    logic i2s_justified;
  } spis_cfg_s;
  typedef struct packed {
    logic busy_flag;
    logic tx_empty_flag;
    logic rx_not_empty_flag;
    logic crc_error_flag;
    logic crc_next_flag;
  } spis_stat_s;
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b,
                                          input logic [7:0] poly);
    crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? poly : 8'h00);
  endfunction : crc_step
endpackage : spis_pkg

// file: rtl/spis_port.sv
// serial port core: spi or i2s, master or slave, with crc and flags
// --------------------------------------------------------------------
// Overview of operation
// - master busy may stick if disabled with tx full
// - select release mid-frame can stick busy
// - tx empty rises while second bit shifts
// - master last bit from feedback, eight-cycle window
// - i2s feedback window of six cycles
// - foreign dma completion mid transfer clears crc next flag
// - i2s slave starts on word-select level at enable
// - master bit from slave receive starts clock
// - transmit crc follows feedback clock
// --------------------------------------------------------------------
`timescale 1ns/1ns
module spis_port (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire spis_pkg::spis_cfg_s cfg_in,
  input wire logic [7:0] crc_poly_in,
  input wire logic crc_next_set_in,
  input wire logic crc_err_clr_in,
  input wire logic dma_active_in,
  input wire logic dma_other_done_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output spis_pkg::spis_stat_s stat_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic ss_n_in,
  input wire logic ws_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out
);
  spis_pkg::spis_state_e state_reg, state_next;
  spis_pkg::spis_cfg_s cfg_prev_reg;
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
  logic [3:0] div_reg, fb_cnt_reg, fb_win;
  logic [2:0] bit_cnt_reg;
  logic [7:0] tx_hold_reg, tx_sh_reg, rx_sh_reg, push_data_reg, rx_word;
  logic [7:0] crc_tx_reg, crc_rx_reg;
  logic sck_reg, tx_full_reg, tx_loaded_reg, crc_phase_reg, push_valid_reg;
  logic crc_next_reg, crc_err_reg, busy_stuck_reg, abort_seen_reg;
  logic i2s_sync_reg, early_clk_reg;
  logic ext_rise, ext_fall, ws_f, ws_act, slave_act, en_rise, en_fall;
  logic sck_run, tick, int_rise, int_fall, sample_ev, shift_ev, last_arm;
  logic fb_hit, fb_miss, done_ev, rx_bit, rx_bit_ev, m_start, s_start, start;
  logic abort, crc_go, tx_taken, buf_ready;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // --------------------------------------------------------------------
  // pin synchronisers: {sck, select, word-select, data in}
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s1_reg <= spis_pkg::SYNC_RST;
      s2_reg <= spis_pkg::SYNC_RST;
      s3_reg <= spis_pkg::SYNC_RST;
      filt_reg <= spis_pkg::SYNC_RST;
      prev_reg <= spis_pkg::SYNC_RST;
    end else begin
      s1_reg <= {sck_in, ss_n_in, ws_in, sdi_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
      prev_reg <= filt_reg;
    end
  end

  assign ext_rise = filt_reg[3] && !prev_reg[3];
  assign ext_fall = !filt_reg[3] && prev_reg[3];
  assign ws_f = filt_reg[1];
  assign ws_act = cfg_in.i2s_justified;
  assign slave_act = cfg_in.i2s_mode ? i2s_sync_reg : !filt_reg[2];
  assign en_rise = cfg_in.port_enable_bit && !cfg_prev_reg.port_enable_bit;
  assign en_fall = !cfg_in.port_enable_bit && cfg_prev_reg.port_enable_bit;

  // --------------------------------------------------------------------
  // master clock generation and shift events
  // --------------------------------------------------------------------
  assign sck_run = cfg_in.master_select_bit && (early_clk_reg || state_reg == spis_pkg::ST_RUN);
  assign tick = sck_run && div_reg == spis_pkg::SCK_HALF_CYC;
  assign int_rise = tick && !sck_reg;
  assign int_fall = tick && sck_reg;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      div_reg <= spis_pkg::DIV_RST;
      sck_reg <= 1'b0;
    end else if (!sck_run) begin
      div_reg <= spis_pkg::DIV_RST;
      if (state_reg == spis_pkg::ST_IDLE) begin
        sck_reg <= 1'b0;
      end
    end else begin
      div_reg <= tick ? spis_pkg::DIV_RST : div_reg + 4'h1;
      if (tick) begin
        sck_reg <= !sck_reg;
      end
    end
  end

  assign sample_ev = cfg_in.master_select_bit ? (int_rise && bit_cnt_reg != spis_pkg::BIT_LAST)
                                              : ext_rise;
  assign shift_ev = cfg_in.master_select_bit ? int_fall : ext_fall;
  assign last_arm = cfg_in.master_select_bit && int_rise && bit_cnt_reg == spis_pkg::BIT_LAST;
  // last master bit waits for the echo of its own edge on the clock pin
  assign fb_win = cfg_in.i2s_mode ? spis_pkg::FB_WIN_I2S : spis_pkg::FB_WIN_SPI;
  assign fb_hit = state_reg == spis_pkg::ST_FBWAIT && ext_rise && fb_cnt_reg <= fb_win;
  assign fb_miss = state_reg == spis_pkg::ST_FBWAIT && !fb_hit && fb_cnt_reg >= fb_win;
  assign rx_bit = fb_miss ? push_data_reg[0] : filt_reg[0];
  assign rx_bit_ev = (state_reg == spis_pkg::ST_RUN && sample_ev) || fb_hit || fb_miss;
  assign rx_word = {rx_sh_reg[6:0], rx_bit};
  assign done_ev = (state_reg == spis_pkg::ST_RUN && !cfg_in.master_select_bit && sample_ev
                    && bit_cnt_reg == spis_pkg::BIT_LAST) || fb_hit || fb_miss;

  // --------------------------------------------------------------------
  // frame sequencing
  // --------------------------------------------------------------------
  assign crc_go = crc_next_reg && cfg_in.crc_en;
  assign m_start = cfg_in.master_select_bit && cfg_in.port_enable_bit && !push_valid_reg
                   && (tx_full_reg || crc_go || cfg_in.receive_only_bit
                       || (cfg_in.half_duplex_bit && !cfg_in.half_duplex_output_enable));
  assign s_start = !cfg_in.master_select_bit && cfg_in.port_enable_bit && slave_act;
  assign start = state_reg == spis_pkg::ST_IDLE && (m_start || s_start);
  assign abort = state_reg == spis_pkg::ST_RUN && !cfg_in.master_select_bit
                 && (!slave_act || !cfg_in.port_enable_bit);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spis_pkg::ST_IDLE: if (start) state_next = spis_pkg::ST_RUN;
      spis_pkg::ST_RUN: begin
        if (abort || done_ev) begin
          state_next = spis_pkg::ST_IDLE;
        end else if (last_arm) begin
          state_next = spis_pkg::ST_FBWAIT;
        end
      end
      spis_pkg::ST_FBWAIT: if (fb_hit || fb_miss) state_next = spis_pkg::ST_IDLE;
      default: state_next = spis_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= spis_pkg::ST_IDLE;
      cfg_prev_reg <= '0;
      fb_cnt_reg <= spis_pkg::FB_CNT_RST;
    end else begin
      state_reg <= state_next;
      cfg_prev_reg <= cfg_in;
      fb_cnt_reg <= (state_reg == spis_pkg::ST_FBWAIT) ? fb_cnt_reg + 4'h1
                                                       : spis_pkg::FB_CNT_RST;
    end
  end

  // --------------------------------------------------------------------
  // shifters; tx holding register frees on the second bit
  // --------------------------------------------------------------------
  assign tx_ready_out = !tx_full_reg;
  assign tx_taken = state_reg == spis_pkg::ST_RUN && shift_ev && tx_loaded_reg
                    && bit_cnt_reg == spis_pkg::BIT_SECOND;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      bit_cnt_reg <= spis_pkg::BIT_CNT_RST;
      tx_sh_reg <= spis_pkg::WORD_RST;
      rx_sh_reg <= spis_pkg::WORD_RST;
      crc_phase_reg <= 1'b0;
      tx_loaded_reg <= 1'b0;
    end else if (start) begin
      bit_cnt_reg <= spis_pkg::BIT_CNT_RST;
      crc_phase_reg <= crc_go;
      tx_loaded_reg <= tx_full_reg && !crc_go;
      tx_sh_reg <= crc_go ? crc_tx_reg : (tx_full_reg ? tx_hold_reg : spis_pkg::WORD_RST);
    end else begin
      if (state_reg == spis_pkg::ST_RUN && shift_ev && bit_cnt_reg != spis_pkg::BIT_CNT_RST) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
      if (tx_taken) begin
        tx_loaded_reg <= 1'b0;
      end
      if (rx_bit_ev) begin
        rx_sh_reg <= rx_word;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_full_reg <= 1'b0;
      tx_hold_reg <= spis_pkg::WORD_RST;
    end else if (tx_valid_in && !tx_full_reg) begin
      tx_full_reg <= 1'b1;
      tx_hold_reg <= tx_data_in;
    end else if (tx_taken) begin
      tx_full_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // received words into the buffer; a full buffer stalls the master
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      push_valid_reg <= 1'b0;
      push_data_reg <= spis_pkg::WORD_RST;
    end else if (done_ev) begin
      push_valid_reg <= 1'b1;
      push_data_reg <= rx_word;
    end else if (buf_ready) begin
      push_valid_reg <= 1'b0;
    end
  end

  spis_buf2 #(.WIDTH(spis_pkg::FRAME_W), .DEPTH(spis_pkg::BUF_DEPTH)) u_rx_buf (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push_valid_reg),
    .in_data_in(push_data_reg),
    .in_ready_out(buf_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );

  // --------------------------------------------------------------------
  // crc: transmit side runs on the clock pin echo in master mode
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || (done_ev && crc_phase_reg)) begin
      crc_tx_reg <= spis_pkg::CRC_RST;
      crc_rx_reg <= spis_pkg::CRC_RST;
    end else if (!crc_phase_reg && state_reg != spis_pkg::ST_IDLE) begin
      if (cfg_in.master_select_bit ? ext_rise : sample_ev) begin
        crc_tx_reg <= spis_pkg::crc_step(crc_tx_reg, tx_sh_reg[7], crc_poly_in);
      end
      if (rx_bit_ev) begin
        crc_rx_reg <= spis_pkg::crc_step(crc_rx_reg, rx_bit, crc_poly_in);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      crc_next_reg <= 1'b0;
      crc_err_reg <= 1'b0;
    end else begin
      if (crc_next_set_in && cfg_in.crc_en) begin
        crc_next_reg <= 1'b1;
      end else if (start && crc_go) begin
        crc_next_reg <= 1'b0;
      end else if (cfg_in.crc_en && !dma_active_in && dma_other_done_in
                   && state_reg != spis_pkg::ST_IDLE) begin
        crc_next_reg <= 1'b0;
      end
      if ((done_ev && crc_phase_reg && rx_word != crc_rx_reg) || (fb_miss && cfg_in.crc_en)) begin
        crc_err_reg <= 1'b1;
      end else if (crc_err_clr_in) begin
        crc_err_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // busy, i2s slave alignment and early master clock
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || en_rise) begin
      busy_stuck_reg <= 1'b0;
      abort_seen_reg <= 1'b0;
    end else begin
      if (abort && cfg_in.port_enable_bit) begin
        abort_seen_reg <= 1'b1;
      end
      if (en_fall && ((cfg_in.master_select_bit && tx_full_reg) || abort_seen_reg)) begin
        busy_stuck_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      i2s_sync_reg <= 1'b0;
    end else if (!cfg_in.port_enable_bit || !cfg_in.i2s_mode || cfg_in.master_select_bit) begin
      i2s_sync_reg <= 1'b0;
    end else if ((en_rise && ws_f == ws_act) || (ws_f != prev_reg[1] && ws_f == ws_act)) begin
      i2s_sync_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !cfg_in.master_select_bit) begin
      early_clk_reg <= 1'b0;
    end else if (!cfg_prev_reg.master_select_bit && !cfg_in.port_enable_bit
                 && (cfg_prev_reg.receive_only_bit || (cfg_prev_reg.half_duplex_bit
                     && !cfg_prev_reg.half_duplex_output_enable))) begin
      early_clk_reg <= 1'b1;
    end
  end

  // master receive-only drops busy for at least two cycles between frames
  assign stat_out.busy_flag = state_reg != spis_pkg::ST_IDLE || busy_stuck_reg;
  assign stat_out.tx_empty_flag = !tx_full_reg;
  assign stat_out.rx_not_empty_flag = rx_valid_out;
  assign stat_out.crc_error_flag = crc_err_reg;
  assign stat_out.crc_next_flag = crc_next_reg;
  assign sck_out = sck_reg;
  assign sck_oe_out = cfg_in.master_select_bit;
  assign sdo_out = tx_sh_reg[7];
  assign sdo_oe_out = cfg_in.port_enable_bit && !cfg_in.receive_only_bit
                      && (!cfg_in.half_duplex_bit || cfg_in.half_duplex_output_enable)
                      && (cfg_in.master_select_bit || slave_act);

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  sequence s_spi_last;
    $rose(state_reg == spis_pkg::ST_FBWAIT) && !cfg_in.i2s_mode;
  endsequence
  sequence s_i2s_last;
    $rose(state_reg == spis_pkg::ST_FBWAIT) && cfg_in.i2s_mode;
  endsequence
  sequence s_abort_then_off;
    abort && cfg_in.port_enable_bit ##1 en_fall;
  endsequence

  a_busy_tx_stuck: assert property (en_fall && cfg_in.master_select_bit && tx_full_reg
    |=> stat_out.busy_flag [*4]) else $error("busy dropped after disable with data");
  a_busy_ss_abort: assert property (s_abort_then_off |=> stat_out.busy_flag [*3])
    else $error("busy dropped after select release and disable");
  a_txe_second_bit: assert property (tx_taken |-> !stat_out.tx_empty_flag
    ##1 stat_out.tx_empty_flag) else $error("tx empty not raised on second bit");
  a_fb_spi_window: assert property (s_spi_last |-> ##[1:8] state_reg != spis_pkg::ST_FBWAIT)
    else $error("spi feedback wait overran window");
  a_fb_miss_keep: assert property (fb_miss && cfg_in.crc_en
    |=> push_data_reg[0] == $past(push_data_reg[0], 2) && stat_out.crc_error_flag)
    else $error("missed last bit not kept");
  a_fb_i2s_window: assert property (s_i2s_last |-> ##[1:6] state_reg != spis_pkg::ST_FBWAIT)
    else $error("i2s feedback wait overran window");
  a_crc_next_dma: assert property (state_reg != spis_pkg::ST_IDLE && cfg_in.crc_en
    && !dma_active_in && dma_other_done_in && !crc_next_set_in |=> !stat_out.crc_next_flag)
    else $error("crc next survived foreign dma completion");
  a_i2s_ws_start: assert property (en_rise && cfg_in.i2s_mode && !cfg_in.master_select_bit
    && ws_f == ws_act && state_reg == spis_pkg::ST_IDLE |=> i2s_sync_reg
    ##1 state_reg == spis_pkg::ST_RUN) else $error("i2s slave did not start at once");
  a_early_clock: assert property (early_clk_reg && !cfg_in.port_enable_bit
    |-> ##[1:5] $changed(sck_out)) else $error("early master clock not running");
  a_crc_fb_only: assert property (cfg_in.master_select_bit && int_rise && !ext_rise
    && state_reg == spis_pkg::ST_RUN |=> crc_tx_reg == $past(crc_tx_reg))
    else $error("transmit crc moved on internal clock");
endmodule : spis_port

// file: tb/spis_peer.sv
// external spi partner: slave on the device clock, or master on its own clock
`timescale 1ns/1ns
module spis_peer (
  input wire logic dev_sck_in,
  input wire logic dev_sdo_in,
  output logic sck_out,
  output logic ss_n_out,
  output logic sdi_out,
  output logic [7:0] got_out,
  output int got_cnt_out
);
  logic [7:0] resp = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic mst = 1'b0;
  int cnt = 0;
  initial begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    sdi_out = 1'b0;
    got_out = 8'h00;
    got_cnt_out = 0;
  end
  task automatic load(input logic [7:0] w);
    mst = 1'b0;
    resp = w;
    sh = w;
    cnt = 0;
    sdi_out = w[7];
  endtask : load
  always @(posedge dev_sck_in) if (!mst) begin
    rx = {rx[6:0], dev_sdo_in};
    cnt++;
    if (cnt == 8) begin
      cnt = 0;
      got_out = rx;
      got_cnt_out++;
    end
  end
  always @(negedge dev_sck_in) if (!mst) begin
    sh = (cnt == 0) ? resp : {sh[6:0], 1'b0};
    sdi_out = sh[7];
  end
  // select stays low over the whole frame and rises again after it
  task automatic drive(input logic [7:0] w);
    mst = 1'b1;
    ss_n_out = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--) begin
      sdi_out = w[i];
      #62;
      sck_out = 1'b1;
      rx = {rx[6:0], dev_sdo_in};
      #63;
      sck_out = 1'b0;
    end
    #125;
    ss_n_out = 1'b1;
    sdi_out = ~sdi_out;
    got_out = rx;
    got_cnt_out++;
  endtask : drive
endmodule : spis_peer

// file: tb/tb.sv
// self-checking bench of the serial port against a queue model
`timescale 1ns/1ns
module tb;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  spis_pkg::spis_cfg_s cfg = '0;
  spis_pkg::spis_stat_s stat;
  logic crc_next_set = 1'b0;
  logic dma_active = 1'b0;
  logic dma_other_done = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic ws = 1'b1;
  logic tx_ready, rx_valid, sck_out, sck_oe, sdo, sdo_oe, peer_sck, ss_n, sdi, sck_pad;
  logic [7:0] rx_data, got, w;
  logic [7:0] exp_rx[$];
  logic [7:0] exp_peer[$];
  logic [31:0] lfsr = 32'hd840;
  int got_cnt, c;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  always #2 sys_clk_in = ~sys_clk_in;
  assign sck_pad = sck_oe ? sck_out : peer_sck;
  spis_port dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg),
    .crc_poly_in(8'h07), .crc_next_set_in(crc_next_set), .crc_err_clr_in(1'b0),
    .dma_active_in(dma_active), .dma_other_done_in(dma_other_done), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .stat_out(stat), .sck_in(sck_pad),
    .sck_out(sck_out), .sck_oe_out(sck_oe), .ss_n_in(ss_n), .ws_in(ws), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe));
  spis_peer peer (.dev_sck_in(sck_out), .dev_sdo_in(sdo), .sck_out(peer_sck),
    .ss_n_out(ss_n), .sdi_out(sdi), .got_out(got), .got_cnt_out(got_cnt));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic rnd;
    lfsr = lfsr_next(lfsr);
    w = lfsr[7:0];
  endtask : rnd
  task automatic ticks(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask : ticks
  task automatic do_reset;
    @(negedge sys_clk_in);
    sys_rst_in = 1'b1;
    ticks(12);
    sys_rst_in = 1'b0;
  endtask : do_reset
  task automatic send(input logic [7:0] d);
    n = 0;
    @(negedge sys_clk_in);
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 5000) begin
      n++;
      @(negedge sys_clk_in);
    end
    @(negedge sys_clk_in);
    tx_valid = 1'b0;
    check({7'h00, stat.tx_empty_flag}, 8'h00, "tx empty after load");
  endtask : send
  task automatic settle;
    n = 0;
    while ((exp_rx.size() + exp_peer.size() != 0 || stat.busy_flag !== 1'b0) && n < 3000) begin
      n++;
      @(negedge sys_clk_in);
    end
    check({6'h00, stat.busy_flag, stat.tx_empty_flag}, 8'h01, "idle after traffic");
  endtask : settle
  task automatic count_sck;
    logic last;
    c = 0;
    last = sck_out;
    repeat (40) begin
      @(negedge sys_clk_in);
      if (sck_out !== last) c++;
      last = sck_out;
    end
  endtask : count_sck
  // receive side of the model, plus the hang limit
  always @(negedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hxx, "rx word");
    end
  end
  always @(got_cnt) #1 check(got, exp_peer.size() ? exp_peer.pop_front() : 8'hxx, "peer word");
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    ticks(12);
    sys_rst_in = 1'b0;
    check({3'h0, stat}, 8'h08, "reset flags");
    check({6'h00, tx_ready, rx_valid}, 8'h02, "reset handshake");
    // master full duplex; receiver stalls until the buffer refuses
    rnd();
    peer.load(w);
    cfg = 8'hc0;
    rx_ready = 1'b0;
    for (int k = 0; k < 4; k++) begin
      rnd();
      exp_peer.push_back(w);
      exp_rx.push_back(peer.resp);
      send(w);
      if (k == 0) begin
        n = 0;
        while (stat.tx_empty_flag !== 1'b1 && n < 500) begin
          n++;
          @(negedge sys_clk_in);
        end
        check({6'h00, stat.busy_flag, stat.tx_empty_flag}, 8'h03, "empty mid frame");
      end
    end
    ticks(300);
    check(8'(exp_peer.size()), 8'h01, "frames while stalled");
    rx_ready = 1'b1;
    settle();
    cfg.port_enable_bit = 1'b0;
    ticks(2);
    // disable with a word still waiting
    cfg = 8'hc0;
    rnd();
    exp_peer.push_back(w);
    exp_rx.push_back(peer.resp);
    send(w);
    rnd();
    send(w);
    cfg.port_enable_bit = 1'b0;
    ticks(200);
    check({6'h00, stat.busy_flag, stat.tx_empty_flag}, 8'h02, "busy stuck");
    check(8'(exp_peer.size()), 8'h00, "frames after disable");
    do_reset();
    check({7'h00, stat.busy_flag}, 8'h00, "busy after reset");
    // slave on the external link clock
    cfg = 8'h80;
    for (int k = 0; k < 2; k++) begin
      rnd();
      exp_peer.push_back(w);
      send(w);
      rnd();
      exp_rx.push_back(w);
      peer.drive(w);
    end
    settle();
    // foreign dma completion drops the crc frame mark mid transfer
    cfg = 8'h84;
    peer.ss_n_out = 1'b0;
    ticks(8);
    crc_next_set = 1'b1;
    ticks(1);
    crc_next_set = 1'b0;
    ticks(1);
    check({7'h00, stat.crc_next_flag}, 8'h01, "crc next set");
    dma_other_done = 1'b1;
    ticks(1);
    dma_other_done = 1'b0;
    ticks(1);
    check({7'h00, stat.crc_next_flag}, 8'h00, "crc next cleared");
    cfg = 8'h04;
    ticks(2);
    peer.ss_n_out = 1'b1;
    // master bit while disabled: clock only after slave receive setups
    do_reset();
    peer.mst = 1'b1;
    rx_ready = 1'b0;
    cfg = 8'h40;
    count_sck();
    check(8'(c), 8'h00, "no clock from plain slave");
    for (int i = 0; i < 2; i++) begin
      do_reset();
      cfg = (i == 0) ? 8'h20 : 8'h10;
      ticks(4);
      cfg.master_select_bit = 1'b1;
      count_sck();
      check({6'h00, sck_oe, c > 4}, 8'h03, "early clock");
    end
    // i2s slave: starts only with word-select active at or after enable
    do_reset();
    ticks(6);
    cfg = 8'h82;
    ticks(8);
    check({6'h00, stat.busy_flag, sdo_oe}, 8'h00, "i2s slave waits");
    ws = 1'b0;
    ticks(8);
    check({6'h00, stat.busy_flag, sdo_oe}, 8'h03, "i2s start on word select");
    cfg = 8'h02;
    ticks(4);
    cfg = 8'h82;
    ticks(4);
    check({7'h00, stat.busy_flag}, 8'h01, "i2s start at enable");
    do_reset();
    wrap_up();
  end
endmodule : tb
